/* hdl/psm_sequencer.sv */
// What this block does
// - qualified option: at least two edges before running
// - memory option: calibrate for 13 teeth first
// - after exit condition, stay running until reset or a watchdog trigger
// - running: dynamic thresholds with operate/release hysteresis
// - peak detector tracks signal in every mode
// - watchdog fires: output stalled, movement still seen
// - watchdog trigger restarts in start-up calibration mode
// - calibration threshold adapts only first 25 edges
// - at power-on, output compares field to threshold
// - low-on-tooth polarity: tooth low, valley high
// - threshold uses peak from n teeth back
// - upper switch level 30% below tracked peak
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module psm_sequencer
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic [11:0] FIELD_I,
  input wire logic FIELD_VLD_I,
  output logic OUT_O,
  output logic IRQ_O,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I
);

  // whole state of the block in one record
  typedef struct packed
  {
    psm_pkg::psm_mode_t mode;
    logic opt_mem;            // 0 qualified, 1 memory-based exit
    logic lt;                 // low_on_tooth_polarity
    logic [3:0] n_teeth;      // peak memory depth in use
    logic [7:0] wd_lim;       // stall count for the watchdog
    logic tooth;              // internal target level, 1 = tooth
    logic out;                // pin level after polarity
    logic dir_up;             // peak tracker heading upward
    logic [11:0] trk;         // running extreme of the tracker
    logic [11:0] last_vl;     // most recent valley
    logic [11:0][11:0] pk_mem;  // positive peaks, newest in entry 0
    logic [11:0] cal_thr;     // fixed calibration threshold
    logic [7:0] edge_cnt;     // output edges since start
    logic [7:0] tooth_cnt;    // teeth seen since start
    logic [7:0] wd_cnt;       // movements since last output edge
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic irq;
    logic awrdy;
    logic wrdy;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } psm_state_t;

  psm_state_t s_r;
  psm_state_t s_nxt;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] psm_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    psm_merge = (old & ~m) | (wd & m);
  endfunction : psm_merge

  // memory tap for n teeth back; out-of-range depths clamp
  logic [3:0] tap;
  assign tap = (s_r.n_teeth == 4'h0) ? 4'h0 :
               (s_r.n_teeth > psm_pkg::NT_MAX) ? (psm_pkg::NT_MAX - 4'h1) :
               (s_r.n_teeth - 4'h1);

  // top bit of the interrupt words, needed by the register decode below
  localparam int INT_TOP = psm_pkg::INT_W - 1;

  // read address falls in the mapped window
  logic rd_map;
  assign rd_map = (AXI_ARADDR_I[7:2] <= psm_pkg::ADDR_THRESH[7:2]);

  // running switch levels from the tapped peak and last valley
  logic [11:0] pk_sel;
  logic [11:0] pp;
  logic [19:0] op_prod;
  logic [19:0] hys_prod;
  logic [11:0] op_thr;
  logic [11:0] rel_thr;
  assign pk_sel = s_r.pk_mem[tap];
  assign pp = (pk_sel > s_r.last_vl) ? (pk_sel - s_r.last_vl) : 12'h000;
  assign op_prod = {8'h00, pp} * {12'h000, psm_pkg::OP_FRAC};
  assign hys_prod = {8'h00, pp} * {12'h000, psm_pkg::HYS_FRAC};
  assign op_thr = pk_sel - op_prod[psm_pkg::FRAC_SHIFT +: 12];
  // release sits below operate by the hysteresis, floored at zero
  assign rel_thr = (op_thr > hys_prod[psm_pkg::FRAC_SHIFT +: 12]) ?
                   (op_thr - hys_prod[psm_pkg::FRAC_SHIFT +: 12]) : 12'h000;

  // peak tracker turning points, independent of mode and output
  logic pk_evt;
  logic vl_evt;
  logic mv_evt;
  assign pk_evt = FIELD_VLD_I && s_r.dir_up && (s_r.trk > FIELD_I) &&
                  ((s_r.trk - FIELD_I) > psm_pkg::PK_DELTA);
  assign vl_evt = FIELD_VLD_I && !s_r.dir_up && (FIELD_I > s_r.trk) &&
                  ((FIELD_I - s_r.trk) > psm_pkg::PK_DELTA);
  assign mv_evt = pk_evt || vl_evt;

  // new target level: fixed compare in calibration, hysteresis when running
  logic tooth_new;
  logic edge_evt;
  always_comb
  begin
    if (s_r.mode == psm_pkg::MODE_CAL)
    begin
      tooth_new = FIELD_I > s_r.cal_thr;
    end
    else if (s_r.tooth)
    begin
      tooth_new = !(FIELD_I < rel_thr);
    end
    else
    begin
      tooth_new = FIELD_I > op_thr;
    end
  end
  assign edge_evt = FIELD_VLD_I && (tooth_new != s_r.tooth);

  // stall: movement keeps coming while the output sits still
  logic wd_fire;
  assign wd_fire = mv_evt && !edge_evt && (s_r.wd_lim != 8'h00) &&
                   (({1'b0, s_r.wd_cnt} + 9'h001) >= {1'b0, s_r.wd_lim});

  // bus handshakes seen this cycle
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic ar_hs;
  assign aw_hs = s_r.awrdy && AXI_AWVALID_I;
  assign w_hs = s_r.wrdy && AXI_WVALID_I;
  assign do_wr = !s_r.awrdy && !s_r.wrdy && !s_r.bvalid;
  assign ar_hs = s_r.arrdy && AXI_ARVALID_I;

  // next-state logic for sequencer, tracker and register file
  always_comb
  begin
    logic [31:0] ctrl_img;
    logic [31:0] rd;
    logic [2:0] set;
    logic run_ok;
    s_nxt = s_r;
    ctrl_img = 32'h0000_0000;
    rd = 32'h0000_0000;
    set = 3'h0;
    run_ok = 1'b0;

    // write address and data are latched apart, in either order
    if (aw_hs)
    begin
      s_nxt.awrdy = 1'b0;
      s_nxt.aw_addr = AXI_AWADDR_I;
    end
    if (w_hs)
    begin
      s_nxt.wrdy = 1'b0;
      s_nxt.w_data = AXI_WDATA_I;
      s_nxt.w_strb = AXI_WSTRB_I;
    end
    // both halves held: apply the write and answer one edge later
    if (do_wr)
    begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = psm_pkg::RESP_OKAY;
      if (s_r.aw_addr[7:2] == psm_pkg::ADDR_CTRL[7:2])
      begin
        ctrl_img[psm_pkg::CTRL_OPT_MEM_BIT] = s_r.opt_mem;
        ctrl_img[psm_pkg::CTRL_LT_BIT] = s_r.lt;
        ctrl_img[psm_pkg::CTRL_NT_LSB +: 4] = s_r.n_teeth;
        ctrl_img = psm_merge(ctrl_img, s_r.w_data, s_r.w_strb);
        s_nxt.opt_mem = ctrl_img[psm_pkg::CTRL_OPT_MEM_BIT];
        s_nxt.lt = ctrl_img[psm_pkg::CTRL_LT_BIT];
        s_nxt.n_teeth = ctrl_img[psm_pkg::CTRL_NT_LSB +: 4];
      end
      else if (s_r.aw_addr[7:2] == psm_pkg::ADDR_WDOG[7:2])
      begin
        if (s_r.w_strb[0])
        begin
          s_nxt.wd_lim = s_r.w_data[7:0];
        end
      end
      else if (s_r.aw_addr[7:2] == psm_pkg::ADDR_INT_STAT[7:2])
      begin
        // one written clears; events below still win
        if (s_r.w_strb[0])
        begin
          s_nxt.int_stat = s_r.int_stat & ~s_r.w_data[INT_TOP:0];
        end
      end
      else if (s_r.aw_addr[7:2] == psm_pkg::ADDR_INT_MASK[7:2])
      begin
        if (s_r.w_strb[0])
        begin
          s_nxt.int_mask = s_r.w_data[INT_TOP:0];
        end
      end
      else if ((s_r.aw_addr[7:2] == psm_pkg::ADDR_STATUS[7:2]) ||
               (s_r.aw_addr[7:2] == psm_pkg::ADDR_THRESH[7:2]))
      begin
        // read-only words ignore writes
        s_nxt.bresp = psm_pkg::RESP_OKAY;
      end
      else
      begin
        s_nxt.bresp = psm_pkg::RESP_SLVERR;
      end
    end
    // response taken: reopen both write channels
    if (s_r.bvalid && AXI_BREADY_I)
    begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awrdy = 1'b1;
      s_nxt.wrdy = 1'b1;
    end

    // read decode, answered on the same edge that takes the address
    if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_CTRL[7:2])
    begin
      rd[psm_pkg::CTRL_OPT_MEM_BIT] = s_r.opt_mem;
      rd[psm_pkg::CTRL_LT_BIT] = s_r.lt;
      rd[psm_pkg::CTRL_NT_LSB +: 4] = s_r.n_teeth;
    end
    else if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_WDOG[7:2])
    begin
      rd[7:0] = s_r.wd_lim;
    end
    else if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_STATUS[7:2])
    begin
      rd[0] = (s_r.mode == psm_pkg::MODE_RUN);
      rd[1] = s_r.edge_cnt < psm_pkg::ADJ_EDGES;
      rd[2] = s_r.tooth;
      rd[15:8] = s_r.edge_cnt;
      rd[23:16] = s_r.tooth_cnt;
      rd[31:24] = s_r.wd_cnt;
    end
    else if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_INT_STAT[7:2])
    begin
      rd[INT_TOP:0] = s_r.int_stat;
    end
    else if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_INT_MASK[7:2])
    begin
      rd[INT_TOP:0] = s_r.int_mask;
    end
    else if (AXI_ARADDR_I[7:2] == psm_pkg::ADDR_THRESH[7:2])
    begin
      rd[11:0] = s_r.cal_thr;
      rd[27:16] = op_thr;
    end
    if (ar_hs)
    begin
      s_nxt.arrdy = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rd_map ? psm_pkg::RESP_OKAY : psm_pkg::RESP_SLVERR;
    end
    if (s_r.rvalid && AXI_RREADY_I)
    begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arrdy = 1'b1;
    end

    // tracker follows the signal in every mode
    if (FIELD_VLD_I)
    begin
      if (pk_evt)
      begin
        s_nxt.pk_mem = {s_r.pk_mem[10:0], s_r.trk};
        s_nxt.dir_up = 1'b0;
        s_nxt.trk = FIELD_I;
      end
      else if (vl_evt)
      begin
        s_nxt.last_vl = s_r.trk;
        s_nxt.dir_up = 1'b1;
        s_nxt.trk = FIELD_I;
      end
      else if (s_r.dir_up ? (FIELD_I > s_r.trk) : (FIELD_I < s_r.trk))
      begin
        s_nxt.trk = FIELD_I;
      end
      s_nxt.tooth = tooth_new;
    end

    // calibration threshold re-centres on each tooth, first edges only
    if (pk_evt && (s_r.edge_cnt < psm_pkg::ADJ_EDGES))
    begin
      s_nxt.cal_thr = 12'(({1'b0, s_r.trk} + {1'b0, s_r.last_vl}) >> 1);
    end

    // counters saturate so long runs never wrap
    if (edge_evt && (s_r.edge_cnt != 8'hFF))
    begin
      s_nxt.edge_cnt = s_r.edge_cnt + 8'h01;
    end
    if (edge_evt && (s_r.edge_cnt == (psm_pkg::ADJ_EDGES - 8'h01)))
    begin
      set[psm_pkg::INT_FREEZE_BIT] = 1'b1;
    end
    if (pk_evt && (s_r.tooth_cnt != 8'hFF))
    begin
      s_nxt.tooth_cnt = s_r.tooth_cnt + 8'h01;
    end
    if (edge_evt)
    begin
      s_nxt.wd_cnt = 8'h00;
    end
    else if (mv_evt && (s_r.wd_cnt != 8'hFF))
    begin
      s_nxt.wd_cnt = s_r.wd_cnt + 8'h01;
    end

    // calibration exit depends on the chosen transition option
    run_ok = s_r.opt_mem ? (s_nxt.tooth_cnt >= psm_pkg::MEM_TEETH)
                         : (s_nxt.edge_cnt >= psm_pkg::QUAL_EDGES);
    if ((s_r.mode == psm_pkg::MODE_CAL) && run_ok)
    begin
      s_nxt.mode = psm_pkg::MODE_RUN;
      set[psm_pkg::INT_RUN_BIT] = 1'b1;
    end

    // watchdog: restart into start-up calibration, clearing mode and counters only
    if (wd_fire)
    begin
      s_nxt.mode = psm_pkg::MODE_CAL;
      s_nxt.edge_cnt = 8'h00;
      s_nxt.tooth_cnt = 8'h00;
      s_nxt.wd_cnt = 8'h00;
      set[psm_pkg::INT_WDOG_BIT] = 1'b1;
      set[psm_pkg::INT_RUN_BIT] = 1'b0;
    end

    // sticky events; a set in the clearing cycle is kept
    s_nxt.int_stat = s_nxt.int_stat | set;
    s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
    s_nxt.out = s_nxt.lt ? !s_nxt.tooth : s_nxt.tooth;
  end

  // the one state register
  always_ff @(posedge SYS_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      s_r <= '0;
      s_r.lt <= psm_pkg::CTRL_LT_RST;
      s_r.opt_mem <= psm_pkg::CTRL_OPT_MEM_RST;
      s_r.n_teeth <= psm_pkg::CTRL_NT_RST;
      s_r.wd_lim <= psm_pkg::WDOG_LIM_RST;
      s_r.cal_thr <= psm_pkg::CAL_THR_RST;
      s_r.out <= psm_pkg::CTRL_LT_RST;
      s_r.dir_up <= 1'b1;
      s_r.awrdy <= 1'b1;
      s_r.wrdy <= 1'b1;
      s_r.arrdy <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ports straight from the state flops
  assign OUT_O = s_r.out;
  assign IRQ_O = s_r.irq;
  assign AXI_AWREADY_O = s_r.awrdy;
  assign AXI_WREADY_O = s_r.wrdy;
  assign AXI_BVALID_O = s_r.bvalid;
  assign AXI_BRESP_O = s_r.bresp;
  assign AXI_ARREADY_O = s_r.arrdy;
  assign AXI_RVALID_O = s_r.rvalid;
  assign AXI_RDATA_O = s_r.rdata;
  assign AXI_RRESP_O = s_r.rresp;

  // checks on the sequencer
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  a_qual_exit: assert property ($rose(s_r.mode == psm_pkg::MODE_RUN) && !$past(s_r.opt_mem)
    |-> s_r.edge_cnt >= psm_pkg::QUAL_EDGES)
    else $error("running entered before two edges");
  a_mem_exit: assert property ($rose(s_r.mode == psm_pkg::MODE_RUN) && $past(s_r.opt_mem)
    |-> s_r.tooth_cnt >= psm_pkg::MEM_TEETH)
    else $error("running entered before 13 teeth");
  a_run_stays: assert property ((s_r.mode == psm_pkg::MODE_RUN) && !wd_fire
    |=> s_r.mode == psm_pkg::MODE_RUN)
    else $error("running mode left without watchdog");
  a_run_hyst_hold: assert property ((s_r.mode == psm_pkg::MODE_RUN) && s_r.tooth && FIELD_VLD_I
    && !(FIELD_I < rel_thr) |=> s_r.tooth)
    else $error("tooth dropped above release level");
  a_tracker_rise: assert property (FIELD_VLD_I && s_r.dir_up && (FIELD_I > s_r.trk)
    |=> s_r.trk == $past(FIELD_I))
    else $error("tracker missed a new maximum");
  a_wdog_fires: assert property (mv_evt && !edge_evt && (s_r.wd_lim != 8'h00)
    && (({1'b0, s_r.wd_cnt} + 9'h001) >= {1'b0, s_r.wd_lim}) |=> s_r.mode == psm_pkg::MODE_CAL)
    else $error("stall not caught by watchdog");
  a_wdog_restart: assert property (wd_fire
    |=> (s_r.edge_cnt == 8'h00) && (s_r.tooth_cnt == 8'h00) && s_r.int_stat[1])
    else $error("watchdog did not restart sequence");
  a_adjust_frozen: assert property (s_r.edge_cnt >= psm_pkg::ADJ_EDGES
    |=> $stable(s_r.cal_thr))
    else $error("threshold moved after 25 edges");
  a_cal_compare: assert property ((s_r.mode == psm_pkg::MODE_CAL) && FIELD_VLD_I
    |=> s_r.tooth == ($past(FIELD_I) > $past(s_r.cal_thr)))
    else $error("calibration output not fixed compare");
  a_pin_polarity: assert property (OUT_O == (s_r.lt ? !s_r.tooth : s_r.tooth))
    else $error("output polarity wrong");
  a_peak_store: assert property (pk_evt |=> s_r.pk_mem[0] == $past(s_r.trk))
    else $error("peak not stored in memory");

  c_run_entry: cover property ($rose(s_r.mode == psm_pkg::MODE_RUN));
  c_wdog_fire: cover property (wd_fire);
  c_freeze: cover property (s_r.int_stat[psm_pkg::INT_FREEZE_BIT]);
  c_bus_write: cover property (s_r.bvalid && AXI_BREADY_I);

endmodule : psm_sequencer

/* hdl/psm_pkg.sv */
package psm_pkg;
  // register byte offsets on the control bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDOG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  // control word field positions
  localparam int CTRL_OPT_MEM_BIT = 0;
  localparam int CTRL_LT_BIT = 1;
  localparam int CTRL_NT_LSB = 4;
  // reset values of software settings
  localparam logic CTRL_OPT_MEM_RST = 1'b0;
  localparam logic CTRL_LT_RST = 1'b1;
  localparam logic [3:0] CTRL_NT_RST = 4'h1;
  localparam logic [7:0] WDOG_LIM_RST = 8'h08;
  localparam logic [11:0] CAL_THR_RST = 12'h800;
  // interrupt bit positions
  localparam int INT_RUN_BIT = 0;
  localparam int INT_WDOG_BIT = 1;
  localparam int INT_FREEZE_BIT = 2;
  localparam int INT_W = 3;
  // sequencing figures
  localparam logic [7:0] QUAL_EDGES = 8'h02;
  localparam logic [7:0] MEM_TEETH = 8'h0D;
  localparam logic [7:0] ADJ_EDGES = 8'h19;
  localparam logic [3:0] NT_MAX = 4'hC;
  localparam int PK_DEPTH = 12;
  // analog-side figures in field counts and 1/256 fractions
  localparam logic [11:0] PK_DELTA = 12'h020;
  localparam logic [7:0] OP_FRAC = 8'h4D;
  localparam logic [7:0] HYS_FRAC = 8'h1A;
  localparam int FRAC_SHIFT = 8;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sequencer modes
  typedef enum logic [0:0]
  {
    MODE_CAL = 1'b0,
    MODE_RUN = 1'b1
  } psm_mode_t;
endpackage : psm_pkg

/* tb/psm_wheel_model.sv */
`timescale 1ns/100ps
// tooth wheel seen through the field path, one sample a cycle
module psm_wheel_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] hi_i,
  input wire logic [11:0] lo_i,
  output logic [11:0] field_o,
  output logic vld_o
);
  logic up_r; // heading toward the tooth
  // triangle between valley and tooth levels; steps divide both levels exactly
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      up_r <= 1'b1;
      field_o <= 12'h000;
      vld_o <= 1'b0;
    end
    else
    begin
      vld_o <= 1'b1;
      // a lowered tooth level just turns the ramp round early
      if (up_r && field_o >= hi_i)
        up_r <= 1'b0;
      else if (up_r)
        field_o <= field_o + 12'h010;
      else if (field_o <= lo_i)
        up_r <= 1'b1;
      else
        field_o <= field_o - 12'h010;
    end
  end
endmodule : psm_wheel_model

/* tb/psm_sequencer_tb.sv */
`timescale 1ns/100ps
module psm_sequencer_tb;
  logic clk = 1'b0, nrst = 1'b0;
  logic [11:0] hi = 12'hC00, lo = 12'h200, field; // wheel levels
  logic fvld, out_pin, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failures = 0, check_count = 0, cycles = 0;

  always #5 clk = ~clk;

  psm_wheel_model wheel (.clk_i(clk), .nrst_i(nrst), .hi_i(hi), .lo_i(lo), .field_o(field),
    .vld_o(fvld));

  psm_sequencer uut (.SYS_CLK_I(clk), .NRST_I(nrst), .FIELD_I(field), .FIELD_VLD_I(fvld),
    .OUT_O(out_pin), .IRQ_O(irq), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid),
    .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
    .AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready));

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      failures++;
      $display("wrong value at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  // single comparison kind; four-state equality so x never matches
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] exp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      awvalid <= ~aw_ok;
      wvalid <= ~w_ok;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk(bresp, exp, "write resp");
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // read: rready held from the start until rvalid is seen
  task rd(input logic [7:0] a, input logic [1:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    chk(rresp, exp, "read resp");
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // reset values, unmapped place, power-on output from fixed threshold
  task t_power_on;
    rd(psm_pkg::ADDR_CTRL, psm_pkg::RESP_OKAY);
    chk(d, 32'h12, "ctrl reset");
    rd(psm_pkg::ADDR_WDOG, psm_pkg::RESP_OKAY);
    chk(d, 32'h08, "wdog reset");
    rd(psm_pkg::ADDR_THRESH, psm_pkg::RESP_OKAY);
    chk(d[11:0], 12'h800, "cal threshold reset");
    rd(8'h18, psm_pkg::RESP_SLVERR);
    chk(d, 32'h0, "unmapped read");
    wr(8'h18, 32'h1, psm_pkg::RESP_SLVERR);
    while (field !== 12'h700)
      @(posedge clk);
    tick(2);
    chk(out_pin, 1'b1, "valley below threshold");
    while (field !== 12'h900)
      @(posedge clk);
    tick(2);
    chk(out_pin, 1'b0, "tooth above threshold");
    $display("test power_on done");
  endtask : t_power_on

  // qualified exit, running thresholds, interrupt mask and clear
  task t_qualified;
    d = 32'h0;
    while (d[0] !== 1'b1)
      rd(psm_pkg::ADDR_STATUS, psm_pkg::RESP_OKAY);
    chk(d[15:8] >= 8'h02, 1'b1, "edges before running");
    chk(d[1], 1'b1, "adjust still open");
    tick(700);
    rd(psm_pkg::ADDR_STATUS, psm_pkg::RESP_OKAY);
    chk(d[0], 1'b1, "still running");
    rd(psm_pkg::ADDR_THRESH, psm_pkg::RESP_OKAY);
    chk(d[11:0], 12'h700, "cal threshold mid level");
    chk(d[27:16], 12'h8FE, "operate level");
    rd(psm_pkg::ADDR_INT_STAT, psm_pkg::RESP_OKAY);
    chk(d[0], 1'b1, "run event");
    chk(irq, 1'b0, "masked irq");
    wr(psm_pkg::ADDR_INT_MASK, 32'h1, psm_pkg::RESP_OKAY);
    tick(2);
    chk(irq, 1'b1, "unmasked irq");
    wr(psm_pkg::ADDR_INT_STAT, 32'h1, psm_pkg::RESP_OKAY);
    tick(2);
    chk(irq, 1'b0, "irq after clear");
    $display("test qualified done");
  endtask : t_qualified

  // adjust window closes on the 25th edge and the threshold holds
  task t_freeze;
    d = 32'h0;
    while (d[15:8] < 8'h19)
      rd(psm_pkg::ADDR_STATUS, psm_pkg::RESP_OKAY);
    chk(d[1], 1'b0, "adjust closed");
    rd(psm_pkg::ADDR_INT_STAT, psm_pkg::RESP_OKAY);
    chk(d[2], 1'b1, "freeze event");
    hi <= 12'hE00;
    tick(1000);
    rd(psm_pkg::ADDR_THRESH, psm_pkg::RESP_OKAY);
    chk(d[11:0], 12'h700, "frozen threshold");
    $display("test freeze done");
  endtask : t_freeze

  // deep peak memory keeps old switch levels, so a shrunk signal stalls
  task t_watchdog;
    logic o;
    int n;
    wr(psm_pkg::ADDR_CTRL, 32'hC2, psm_pkg::RESP_OKAY);
    wr(psm_pkg::ADDR_WDOG, 32'h3, psm_pkg::RESP_OKAY);
    hi <= 12'h600;
    d = 32'h0;
    while (d[1] !== 1'b1)
      rd(psm_pkg::ADDR_INT_STAT, psm_pkg::RESP_OKAY);
    chk(d[1], 1'b1, "watchdog event");
    rd(psm_pkg::ADDR_STATUS, psm_pkg::RESP_OKAY);
    chk(d[0], 1'b0, "back in calibration");
    wr(psm_pkg::ADDR_INT_STAT, 32'h2, psm_pkg::RESP_OKAY);
    o = out_pin;
    for (n = 0; n < 3000 && out_pin === o; n++)
      @(posedge clk);
    chk(out_pin !== o, 1'b1, "switching resumes");
    rd(psm_pkg::ADDR_THRESH, psm_pkg::RESP_OKAY);
    chk(d[11:0], 12'h400, "threshold readapted");
    $display("test watchdog done");
  endtask : t_watchdog

  // memory-based exit only after 13 teeth
  task t_memory;
    hi <= 12'hC00;
    nrst <= 1'b0;
    tick(16);
    nrst <= 1'b1;
    @(posedge clk);
    wr(psm_pkg::ADDR_CTRL, 32'h13, psm_pkg::RESP_OKAY);
    d = 32'h0;
    while (d[0] !== 1'b1)
      rd(psm_pkg::ADDR_STATUS, psm_pkg::RESP_OKAY);
    chk(d[23:16] >= 8'h0D, 1'b1, "teeth before running");
    $display("test memory done");
  endtask : t_memory

  initial
  begin
    tick(16);
    nrst <= 1'b1;
    @(posedge clk);
    t_power_on();
    t_qualified();
    t_freeze();
    t_watchdog();
    t_memory();
    print_verdict();
  end
endmodule : psm_sequencer_tb
